// ==== common/ptr_pkg.sv ====
// shared constants and types for the protector threshold and eeprom register block
// assumes a single 200 MHz clock and a byte-wide command port fed by the serial front end
package ptr_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_MHZ = 200;
  localparam int OV_DELAY_US = 1000;     // overvoltage qualify delay
  localparam int OC_DELAY_US = 10000;    // overcurrent qualify delay
  localparam int SC_DELAY_US = 100;      // short-circuit qualify delay
  localparam int COPY_TIME_US = 10000;   // nonvolatile programming time
  localparam int OV_DELAY_CYC = OV_DELAY_US * CLK_MHZ;
  localparam int OC_DELAY_CYC = OC_DELAY_US * CLK_MHZ;
  localparam int SC_DELAY_CYC = SC_DELAY_US * CLK_MHZ;
  localparam int COPY_TIME_CYC = COPY_TIME_US * CLK_MHZ;

  // ==========================================================================
  // address map
  localparam logic [7:0] ADDR_ACR_MSB = 8'h10;
  localparam logic [7:0] ADDR_ACR_LSB = 8'h11;
  localparam logic [7:0] ADDR_AGE = 8'h14;
  localparam logic [7:0] ADDR_SPECIAL = 8'h15;
  localparam logic [7:0] ADDR_EEREG = 8'h1F;
  localparam logic [7:0] USER_LO = 8'h20;
  localparam logic [7:0] USER_HI = 8'h2F;
  localparam logic [7:0] PARAM_LO = 8'h60;
  localparam logic [7:0] PARAM_HI = 8'h80;
  localparam logic [7:0] ADDR_AGING_MSB = 8'h62;
  localparam logic [7:0] ADDR_FULL40_MSB = 8'h6A;
  localparam logic [7:0] ADDR_GAIN_MSB = 8'h78;
  localparam logic [7:0] ADDR_OV_THR = 8'h7F;
  localparam logic [7:0] RESERVED_VAL = 8'hFF;
  localparam logic [7:0] ERASED_VAL = 8'hFF;

  // ==========================================================================
  // field positions
  localparam int SF_HASH_BIT = 1;
  localparam int SF_IO_BIT = 0;
  localparam int EE_COPY_BIT = 7;
  localparam int EE_LOCK_BIT = 6;
  localparam int EE_PARAM_LK_BIT = 1;
  localparam int EE_USER_LK_BIT = 0;
  localparam int GAIN_OC_HI_BIT = 7;
  localparam int GAIN_OC_LO_BIT = 6;
  localparam int GAIN_SC_BIT = 5;

  // ==========================================================================
  // reset values and threshold figures (mV of sense voltage; OV_BASE in 5V/1024 steps)
  localparam logic IO_CTL_RESET = 1'b1;
  localparam logic [9:0] OV_BASE = 10'h2A6;  // 678 steps of 5V/1024
  localparam logic signed [15:0] COC_MV_TAB [4] = '{16'h0019, 16'h0026, 16'h0032, 16'h004B};
  localparam logic signed [15:0] DOC_MV_TAB [4] = '{16'h0026, 16'h0032, 16'h004B, 16'h0064};
  localparam logic signed [15:0] SC_MV_LO = 16'h0096;  // 150 mV
  localparam logic signed [15:0] SC_MV_HI = 16'h012C;  // 300 mV

  // ==========================================================================
  // qualifier indices and block codes
  localparam int QI_OV = 0;
  localparam int QI_COC = 1;
  localparam int QI_DOC = 2;
  localparam int QI_SC = 3;
  localparam logic BLK_USER = 1'b0;
  localparam logic BLK_PARAM = 1'b1;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    PTR_OP_READ, PTR_OP_WRITE, PTR_OP_COPY, PTR_OP_RECALL, PTR_OP_LOCK, PTR_OP_END
  } ptr_op_t;

  typedef enum logic {CP_IDLE, CP_BUSY} ptr_copy_st_t;

  typedef struct packed {
    ptr_op_t op;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ptr_req_t;

  typedef struct packed {
    logic [9:0] cell1;               // cell voltage, 5V/1024 units
    logic [9:0] cell2;
    logic signed [15:0] sense_mv;    // sense voltage, negative while charging
  } ptr_meas_t;

endpackage : ptr_pkg

// ==== hw/ptr_qualify.sv ====
// persistence qualifier: a condition must hold without a gap before it is reported
// assumes cond is already synchronous to clk
`timescale 1ns/1ps
module ptr_qualify #(
  parameter int CNT_W = 24,
  parameter logic [CNT_W-1:0] DELAY = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cond,
  output logic qual
);

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic qual_q, qual_d;

  // ==========================================================================
  // hold counter, saturating at the delay; any gap restarts it
  always_comb begin
    cnt_d = '0;
    if (cond) begin
      cnt_d = (cnt_q == DELAY) ? cnt_q : cnt_q + 1'b1;
    end
    qual_d = cond && (cnt_q == DELAY);  // see R05 see R06 see R01
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      qual_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      qual_q <= qual_d;
    end
  end

  assign qual = qual_q;

  // ==========================================================================
  // checks
  property p_rise_after_hold;
    @(posedge clk) disable iff (!rst_n) $rose(qual_q) |-> $past(cond) && $past(cnt_q) == DELAY;
  endproperty
  a_rise_after_hold: assert property (p_rise_after_hold) // see R05
    else $error("qualified without a full hold");

  property p_gap_clears;
    @(posedge clk) disable iff (!rst_n) !cond |=> !qual_q && cnt_q == '0;
  endproperty
  a_gap_clears: assert property (p_gap_clears) // see R06
    else $error("short excursion not ignored");

endmodule : ptr_qualify

// ==== hw/ptr_regs_top.sv ====
// protector thresholds, special-feature and eeprom lock registers with shadow ram
// assumes a serial front end that turns host commands into one-cycle requests on clk
`timescale 1ns/1ps

// Summary of operation
// R01 - overvoltage fault when either cell stays above threshold for the full delay
// R02 - threshold is 678 plus twice the 7-bit code, in 5V/1024 steps
// R03 - two select bits pick charge and discharge overcurrent thresholds
// R04 - one select bit picks 150 mV or 300 mV short-circuit threshold
// R05 - overcurrent turns FET off only after persisting beyond its delay
// R06 - short circuit turns FET off only after persisting beyond its delay
// R07 - hash-busy bit reads 1 while a hash runs, else 0
// R08 - io control 0 drives the pin low, 1 releases it
// R09 - reading io control returns the pin level
// R10 - io control forced to 1 at power-up and on sleep entry
// R11 - host must not drive io low while it is a power-switch input
// R12 - copy flag reads 1 during copy; eeprom writes then are dropped
// R13 - lock works only with lock enable set; enable clears unless lock follows
// R14 - parameter block lock flag shows block 60h-80h locked
// R15 - user block lock flag shows block 20h-2Fh locked
// R16 - locked block refuses writes forever; reads unaffected
// R17 - 256-byte space; reserved bytes read FFh and should not be written
// R18 - 16-bit values: MSB at even address, LSB at next odd
// R19 - reading an MSB latches both bytes until the read command ends
// R20 - reads and writes hit shadow ram; copy and recall move blocks
// R21 - block under copy is inaccessible until programming time elapses
// R22 - charge and age saved to eeprom on each 4% capacity boundary crossing
// R23 - enables turn FETs on only when no fault is present
// R24 - overvoltage or charge overcurrent drops charge FET; others drop discharge FET
// R25 - overvoltage threshold is read/write in shadow, recalled at power-up
module ptr_regs_top import ptr_pkg::*; #(
  parameter int OV_DLY = OV_DELAY_CYC,
  parameter int OC_DLY = OC_DELAY_CYC,
  parameter int SC_DLY = SC_DELAY_CYC,
  parameter int COPY_DLY = COPY_TIME_CYC,
  parameter int CNT_W = 24
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire ptr_req_t req,
  input wire ptr_meas_t meas,
  input wire logic charge_fet_enable,
  input wire logic discharge_fet_enable,
  input wire logic hash_busy,
  input wire logic sleep_enter,
  input wire logic [15:0] accumulated_charge,
  input wire logic [7:0] age_scalar,
  input wire logic [7:0] active_rel_capacity,
  input wire logic io_pin_i,
  output logic io_pin_o,
  output logic io_pin_oe,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic chg_fet_on,
  output logic dis_fet_on,
  output logic ov_fault,
  output logic copy_in_progress
);

  // ==========================================================================
  // state
  logic [7:0] sh_q [256];
  logic [7:0] sh_d [256];
  logic [7:0] ee_q [256];
  logic [7:0] ee_d [256];
  ptr_copy_st_t cp_st_q, cp_st_d;
  logic [CNT_W-1:0] cp_cnt_q, cp_cnt_d;
  logic cp_blk_q, cp_blk_d;
  logic user_lk_q, user_lk_d, param_lk_q, param_lk_d;
  logic lock_en_q, lock_en_d, first_q, first_d, boot_q, boot_d;
  logic lat_v_q, lat_v_d;
  logic [7:0] lat_q, lat_d, lat_a_q, lat_a_d;
  logic io_ctl_q, io_ctl_d, io_oe_q, io_oe_d, io_meta_q, io_sync_q, io_out_q;
  logic rsp_valid_q, rsp_valid_d;
  logic [7:0] rsp_data_q, rsp_data_d;
  logic [5:0] bucket_q, bucket_d;
  logic [9:0] thr_q, thr_d;
  logic signed [15:0] coc_q, coc_d, doc_q, doc_d, sc_q, sc_d;
  logic chg_q, chg_d, dis_q, dis_d, ovf_q, ovf_d;
  logic [3:0] raw, qual;
  logic cp_busy, rd_req, wr_req, cp_req, rc_req, lk_req, end_req;
  logic ee_wr_ok, cp_start, rc_start, lk_do, cp_done, save_ev;
  logic [7:0] rd_data;

  // ==========================================================================
  // address decoding helpers
  function automatic logic in_user(input logic [7:0] a);
    return (a >= USER_LO) && (a <= USER_HI);
  endfunction : in_user

  function automatic logic in_param(input logic [7:0] a);
    return (a >= PARAM_LO) && (a <= PARAM_HI);
  endfunction : in_param

  function automatic logic is_ee(input logic [7:0] a);
    return in_user(a) || in_param(a);
  endfunction : is_ee

  function automatic logic blk_of(input logic [7:0] a);
    return in_param(a) ? BLK_PARAM : BLK_USER;
  endfunction : blk_of

  function automatic logic is_locked(input logic [7:0] a);
    return (in_user(a) && user_lk_q) || (in_param(a) && param_lk_q);
  endfunction : is_locked

  // even addresses heading a 16-bit pair
  function automatic logic is_pair_msb(input logic [7:0] a);
    return (a == ADDR_ACR_MSB) || (a == ADDR_AGING_MSB) || (a == ADDR_FULL40_MSB)
      || (a == ADDR_GAIN_MSB);
  endfunction : is_pair_msb

  function automatic logic blk_busy(input logic [7:0] a);
    return cp_busy && is_ee(a) && (blk_of(a) == cp_blk_q);
  endfunction : blk_busy

  // live byte at an address; unmapped and reserved bytes read as all ones
  function automatic logic [7:0] map_byte(input logic [7:0] a);
    logic [7:0] b;
    b = RESERVED_VAL;  // see R17
    if (a == ADDR_ACR_MSB) begin
      b = accumulated_charge[15:8];  // see R18
    end else if (a == ADDR_ACR_LSB) begin
      b = accumulated_charge[7:0];
    end else if (a == ADDR_AGE) begin
      b = age_scalar;
    end else if (a == ADDR_SPECIAL) begin
      b = 8'h00;
      b[SF_HASH_BIT] = hash_busy;  // see R07
      b[SF_IO_BIT] = io_sync_q;  // see R09
    end else if (a == ADDR_EEREG) begin
      b = 8'h00;
      b[EE_COPY_BIT] = cp_busy;  // see R12
      b[EE_LOCK_BIT] = lock_en_q;
      b[EE_PARAM_LK_BIT] = param_lk_q;  // see R14
      b[EE_USER_LK_BIT] = user_lk_q;  // see R15
    end else if (is_ee(a) && !blk_busy(a)) begin
      b = sh_q[a];  // see R20 see R21
    end
    return b;
  endfunction : map_byte

  // ==========================================================================
  // request decode
  assign cp_busy = (cp_st_q == CP_BUSY);
  assign rd_req = req_valid && (req.op == PTR_OP_READ);
  assign wr_req = req_valid && (req.op == PTR_OP_WRITE);
  assign cp_req = req_valid && (req.op == PTR_OP_COPY);
  assign rc_req = req_valid && (req.op == PTR_OP_RECALL);
  assign lk_req = req_valid && (req.op == PTR_OP_LOCK);
  assign end_req = req_valid && (req.op == PTR_OP_END);
  // writes to reserved or read-only bytes simply fall through
  // helpers read lock, copy and live state beyond their arguments, so keep them in a process
  always_comb begin
    ee_wr_ok = wr_req && is_ee(req.addr) && !cp_busy && !is_locked(req.addr);  // see R12 see R16
    cp_start = cp_req && is_ee(req.addr) && !cp_busy && !is_locked(req.addr);
    rc_start = rc_req && is_ee(req.addr) && !cp_busy;
    lk_do = lk_req && lock_en_q && is_ee(req.addr) && !cp_busy;  // see R13
    rd_data = (lat_v_q && req.addr == lat_a_q) ? lat_q : map_byte(req.addr);  // see R19
  end
  assign cp_done = cp_busy && (cp_cnt_q == '0);
  assign save_ev = !boot_q && (active_rel_capacity[7:2] != bucket_q);  // see R22

  // ==========================================================================
  // shadow ram and eeprom cells; cells reset to erased to model a blank part
  always_comb begin
    sh_d = sh_q;
    ee_d = ee_q;
    for (int i = 0; i < 256; i++) begin
      if (is_ee(8'(i)) && (boot_q || (rc_start && blk_of(8'(i)) == blk_of(req.addr)))) begin
        sh_d[i] = ee_q[i];  // see R25 see R20
      end
      if (cp_done && is_ee(8'(i)) && blk_of(8'(i)) == cp_blk_q) begin
        ee_d[i] = sh_q[i];  // see R20
      end
    end
    if (ee_wr_ok) begin
      sh_d[req.addr] = req.wdata;  // see R25
    end
    if (save_ev) begin
      ee_d[ADDR_ACR_MSB] = accumulated_charge[15:8];  // see R22
      ee_d[ADDR_ACR_LSB] = accumulated_charge[7:0];
      ee_d[ADDR_AGE] = age_scalar;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) begin
        sh_q[i] <= RESERVED_VAL;
        ee_q[i] <= ERASED_VAL;
      end
    end else begin
      sh_q <= sh_d;
      ee_q <= ee_d;
    end
  end

  // ==========================================================================
  // copy sequencer, locks, lock enable, pair latch, io control, read answer
  always_comb begin
    cp_st_d = cp_st_q;
    cp_cnt_d = cp_cnt_q;
    cp_blk_d = cp_blk_q;
    unique case (cp_st_q)
      CP_IDLE: if (cp_start) begin
        cp_st_d = CP_BUSY;  // see R21
        cp_cnt_d = CNT_W'(COPY_DLY - 1);
        cp_blk_d = blk_of(req.addr);
      end
      CP_BUSY: if (cp_cnt_q == '0) begin
        cp_st_d = CP_IDLE;
      end else begin
        cp_cnt_d = cp_cnt_q - 1'b1;
      end
    endcase
    user_lk_d = user_lk_q || (lk_do && !in_param(req.addr));  // see R16
    param_lk_d = param_lk_q || (lk_do && in_param(req.addr));
    lock_en_d = lock_en_q;
    if (first_q && req_valid && !lk_req && !end_req) begin
      lock_en_d = 1'b0;  // see R13
    end
    if (lk_do) begin
      lock_en_d = 1'b0;
    end
    if (wr_req && req.addr == ADDR_EEREG) begin
      lock_en_d = req.wdata[EE_LOCK_BIT];
    end
    first_d = end_req ? 1'b1 : (req_valid ? 1'b0 : first_q);
    lat_v_d = lat_v_q;
    lat_d = lat_q;
    lat_a_d = lat_a_q;
    if (end_req) begin
      lat_v_d = 1'b0;
    end else if (rd_req && is_pair_msb(req.addr)) begin
      lat_v_d = 1'b1;  // see R19
      lat_a_d = req.addr + 8'h01;
      lat_d = map_byte(req.addr + 8'h01);
    end
    // no guard against the power-switch use of the pin; that is on the host
    io_ctl_d = io_ctl_q;
    if (wr_req && req.addr == ADDR_SPECIAL) begin
      io_ctl_d = req.wdata[SF_IO_BIT];  // see R08 see R11
    end
    if (sleep_enter) begin
      io_ctl_d = IO_CTL_RESET;  // see R10
    end
    io_oe_d = !io_ctl_d;  // see R08
    rsp_valid_d = rd_req;
    rsp_data_d = rd_req ? rd_data : rsp_data_q;
    bucket_d = active_rel_capacity[7:2];
    boot_d = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_st_q <= CP_IDLE;
      cp_cnt_q <= '0;
      cp_blk_q <= BLK_USER;
      user_lk_q <= 1'b0;
      param_lk_q <= 1'b0;
      lock_en_q <= 1'b0;
      first_q <= 1'b1;
      lat_v_q <= 1'b0;
      lat_q <= 8'h00;
      lat_a_q <= 8'h00;
      io_ctl_q <= IO_CTL_RESET;
      io_oe_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
      bucket_q <= 6'h00;
      boot_q <= 1'b1;
    end else begin
      cp_st_q <= cp_st_d;
      cp_cnt_q <= cp_cnt_d;
      cp_blk_q <= cp_blk_d;
      user_lk_q <= user_lk_d;
      param_lk_q <= param_lk_d;
      lock_en_q <= lock_en_d;
      first_q <= first_d;
      lat_v_q <= lat_v_d;
      lat_q <= lat_d;
      lat_a_q <= lat_a_d;
      io_ctl_q <= io_ctl_d;
      io_oe_q <= io_oe_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
      bucket_q <= bucket_d;
      boot_q <= boot_d;
    end
  end

  // io pin comes from outside, two flops before anything reads it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_meta_q <= 1'b0;
      io_sync_q <= 1'b0;
      io_out_q <= 1'b0;
    end else begin
      io_meta_q <= io_pin_i;
      io_sync_q <= io_meta_q;
      io_out_q <= 1'b0;  // open drain only ever pulls low
    end
  end

  // ==========================================================================
  // protection thresholds from shadow, qualified faults and FET drive
  always_comb begin
    thr_d = OV_BASE + {2'b00, sh_q[ADDR_OV_THR][6:0], 1'b0};  // see R02
    coc_d = COC_MV_TAB[{sh_q[ADDR_GAIN_MSB][GAIN_OC_HI_BIT], sh_q[ADDR_GAIN_MSB][GAIN_OC_LO_BIT]}];
    doc_d = DOC_MV_TAB[{sh_q[ADDR_GAIN_MSB][GAIN_OC_HI_BIT], sh_q[ADDR_GAIN_MSB][GAIN_OC_LO_BIT]}];
    sc_d = sh_q[ADDR_GAIN_MSB][GAIN_SC_BIT] ? SC_MV_HI : SC_MV_LO;  // see R04
    raw[QI_OV] = (meas.cell1 > thr_q) || (meas.cell2 > thr_q);  // see R01
    raw[QI_COC] = meas.sense_mv < -coc_q;  // see R03
    raw[QI_DOC] = meas.sense_mv > doc_q;
    raw[QI_SC] = meas.sense_mv > sc_q;
    chg_d = charge_fet_enable && !qual[QI_OV] && !qual[QI_COC];  // see R23 see R24
    dis_d = discharge_fet_enable && !qual[QI_DOC] && !qual[QI_SC];  // see R23 see R24
    ovf_d = qual[QI_OV];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_q <= 10'h3FF;
      coc_q <= 16'h0000;
      doc_q <= 16'h7FFF;
      sc_q <= 16'h7FFF;
      chg_q <= 1'b0;
      dis_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      thr_q <= thr_d;
      coc_q <= coc_d;
      doc_q <= doc_d;
      sc_q <= sc_d;
      chg_q <= chg_d;
      dis_q <= dis_d;
      ovf_q <= ovf_d;
    end
  end

  localparam int QUAL_DLY [4] = '{OV_DLY, OC_DLY, OC_DLY, SC_DLY};

  // one persistence qualifier per fault source
  for (genvar g = 0; g < 4; g++) begin : g_qual
    ptr_qualify #(
      .CNT_W(CNT_W),
      .DELAY(CNT_W'(QUAL_DLY[g]))
    ) u_qual (
      .clk(clk),
      .rst_n(rst_n),
      .cond(raw[g]),
      .qual(qual[g])
    );
  end

  assign io_pin_o = io_out_q;
  assign io_pin_oe = io_oe_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign chg_fet_on = chg_q;
  assign dis_fet_on = dis_q;
  assign ov_fault = ovf_q;
  assign copy_in_progress = cp_busy;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_chg_fault;
    (qual[QI_OV] || qual[QI_COC]) |=> !chg_fet_on;
  endproperty
  a_chg_fault: assert property (p_chg_fault) // see R24
    else $error("charge FET on during fault");

  property p_dis_fault;
    (qual[QI_DOC] || qual[QI_SC]) |=> !dis_fet_on;
  endproperty
  a_dis_fault: assert property (p_dis_fault) // see R23
    else $error("discharge FET on during fault");

  property p_sleep_io;
    sleep_enter |=> io_ctl_q && !io_pin_oe;
  endproperty
  a_sleep_io: assert property (p_sleep_io) // see R10
    else $error("io not released on sleep");

  property p_io_low;
    (wr_req && req.addr == ADDR_SPECIAL && !req.wdata[SF_IO_BIT] && !sleep_enter) |=> io_pin_oe;
  endproperty
  a_io_low: assert property (p_io_low) // see R08
    else $error("io driver not enabled");

  property p_io_read;
    (rd_req && req.addr == ADDR_SPECIAL) |=> rsp_valid && rsp_data[SF_IO_BIT] == $past(io_sync_q);
  endproperty
  a_io_read: assert property (p_io_read) // see R09
    else $error("io read not pin level");

  property p_reserved;
    (rd_req && req.addr == PARAM_HI + 8'h01) |=> rsp_valid && rsp_data == RESERVED_VAL;
  endproperty
  a_reserved: assert property (p_reserved) // see R17
    else $error("reserved byte not all ones");

  // a write into a locked block must leave its shadow byte untouched
  property p_lock_kept;
    (wr_req && is_locked(req.addr)) |=> sh_q[$past(req.addr)] == $past(sh_q[req.addr]);
  endproperty
  a_lock_kept: assert property (p_lock_kept) // see R16
    else $error("block unlocked");

  property p_lock_en_drop;
    (lock_en_q && first_q && req_valid && !lk_req && !end_req && !wr_req) |=> !lock_en_q;
  endproperty
  a_lock_en_drop: assert property (p_lock_en_drop) // see R13
    else $error("lock enable survived other command");

  property p_copy_hold;
    (cp_start && COPY_DLY >= 8) |=> copy_in_progress [*8];
  endproperty
  a_copy_hold: assert property (p_copy_hold) // see R12
    else $error("copy flag dropped early");

  property p_pair_latch;
    (rd_req && lat_v_q && req.addr == lat_a_q) |=> rsp_data == $past(lat_q);
  endproperty
  a_pair_latch: assert property (p_pair_latch) // see R19
    else $error("pair LSB not from snapshot");

  property p_autosave;
    save_ev |=> ee_q[ADDR_AGE] == $past(age_scalar);
  endproperty
  a_autosave: assert property (p_autosave) // see R22
    else $error("age not saved on boundary");

  c_copy: cover property (cp_start ##1 copy_in_progress);
  c_lock: cover property (lk_do ##1 user_lk_q);
  c_ov: cover property ($rose(ov_fault));
  c_pair: cover property (rd_req && is_pair_msb(req.addr) ##1 rd_req && req.addr == lat_a_q);

endmodule : ptr_regs_top

// ==== test/ptr_host_model.sv ====
// host controller model: issues one-cycle register requests
// assumes the bench calls send at the falling edge of clk
`timescale 1ns/1ps
module ptr_host_model import ptr_pkg::*; (
  input wire logic clk,
  output logic req_valid,
  output ptr_req_t req
);
  // ==========
  // request driver
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // never pulls io low while it serves as a power-switch input
  // lock goes out first after the first enable write, a read precedes the second; reserved bytes are only read
  task automatic send(input ptr_op_t op, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req_valid = 1'b1;
    req = '{op, a, d};
    @(negedge clk);
    req_valid = 1'b0;
    req = '{PTR_OP_END, ~a, ~d}; // released address and data lines show the inverse, not stale data; op shows END
  endtask : send
endmodule : ptr_host_model

// ==== test/test_protector_threshold_and_eeprom_regs.sv ====
// bench for the threshold and eeprom register block
// assumes short delay parameters so faults and copies finish quickly
`timescale 1ns/1ps
module test_protector_threshold_and_eeprom_regs import ptr_pkg::*;;
  logic clk = 1'b0, rst_n = 1'b0, hash_busy = 1'b0, sleep_enter = 1'b0;
  logic charge_fet_enable = 1'b1, discharge_fet_enable = 1'b1, req_valid;
  logic io_pin_o, io_pin_oe, rsp_valid, chg_fet_on, dis_fet_on, ov_fault, copy_in_progress;
  logic [15:0] accumulated_charge = 16'h1234;
  logic [7:0] age_scalar = 8'h40, active_rel_capacity = 8'h32, rsp_data, data, exp_q[$];
  logic [6:0] code;
  ptr_req_t req;
  ptr_meas_t meas = '{10'h1F4, 10'h1F4, 16'h0000};
  int fail_count = 0, tests_run = 0, cycles = 0;
  int doc[4] = '{38, 50, 75, 100};
  int coc[4] = '{-25, -38, -50, -75};
  integer seed = 32'hF3D4EEDB;
  wire logic io_pin_i = io_pin_oe ? 1'b0 : 1'b1; // external pull-up when released
  // ==========
  // instances and clock
  ptr_host_model u_ptr_host_model (.clk, .req_valid, .req);
  ptr_regs_top #(.OV_DLY(20), .OC_DLY(30), .SC_DLY(10), .COPY_DLY(40)) u_ptr_regs_top (
    .clk, .rst_n, .req_valid, .req, .meas, .charge_fet_enable, .discharge_fet_enable,
    .hash_busy, .sleep_enter, .accumulated_charge, .age_scalar, .active_rel_capacity,
    .io_pin_i, .io_pin_o, .io_pin_oe, .rsp_valid, .rsp_data, .chg_fet_on, .dis_fet_on,
    .ov_fault, .copy_in_progress);
  always #2.5 clk = ~clk;
  // ==========
  // tasks
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic check_byte(input logic [7:0] got, input logic [7:0] e);
    tests_run++;
    if (got !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
    end
  endtask : check_byte
  task automatic check_bit(input logic got, input logic e);
    check_byte({7'h00, got}, {7'h00, e});
  endtask : check_bit
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic snd(input ptr_op_t op, input logic [7:0] a, input logic [7:0] d);
    u_ptr_host_model.send(op, a, d);
  endtask : snd
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    snd(PTR_OP_READ, a, 8'h00);
  endtask : rd
  // hold a sense level, then compare both gate drives and let the fault clear
  task automatic pulse(input int mv, input int n, input logic e_dis, input logic e_chg);
    meas.sense_mv = 16'(mv);
    cyc(n);
    check_bit(dis_fet_on, e_dis);
    check_bit(chg_fet_on, e_chg);
    meas.sense_mv = 16'h0000;
    cyc(4);
  endtask : pulse
  // ==========
  // response monitor: oldest note against each answer
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) check_byte(rsp_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
  end
  // hang guard well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ==========
  // main sequence
  initial begin
    data = 8'($random(seed));
    code = 7'($random(seed));
    cyc(20);
    rst_n = 1'b1;
    cyc(2);
    rd(ADDR_SPECIAL, 8'h01);
    hash_busy = 1'b1;
    cyc(3);
    rd(ADDR_SPECIAL, 8'h03);
    hash_busy = 1'b0;
    snd(PTR_OP_WRITE, ADDR_SPECIAL, 8'h00);
    cyc(3);
    check_bit(io_pin_oe, 1'b1);
    check_bit(io_pin_o, 1'b0);
    rd(ADDR_SPECIAL, 8'h00);
    sleep_enter = 1'b1;
    cyc(3);
    check_bit(io_pin_oe, 1'b0);
    sleep_enter = 1'b0;
    cyc(3);
    rd(ADDR_SPECIAL, 8'h01);
    rd(8'h30, 8'hFF);
    rd(8'h81, 8'hFF);
    rd(ADDR_ACR_MSB, 8'h12);
    accumulated_charge = 16'h5678;
    cyc(2);
    rd(ADDR_ACR_LSB, 8'h34);
    snd(PTR_OP_END, 8'h00, 8'h00);
    rd(ADDR_ACR_LSB, 8'h78);
    snd(PTR_OP_END, 8'h00, 8'h00);
    snd(PTR_OP_WRITE, USER_LO, data);
    rd(USER_LO, data);
    snd(PTR_OP_COPY, USER_LO, 8'h00);
    snd(PTR_OP_WRITE, 8'h21, 8'hAA);
    check_bit(copy_in_progress, 1'b1);
    rd(USER_LO, 8'hFF);
    for (int i = 0; i < 60 && copy_in_progress === 1'b1; i++) cyc(1);
    check_bit(copy_in_progress, 1'b0);
    rd(8'h21, 8'hFF);
    snd(PTR_OP_RECALL, USER_LO, 8'h00);
    rd(USER_LO, data);
    snd(PTR_OP_WRITE, ADDR_EEREG, 8'h40);
    snd(PTR_OP_END, 8'h00, 8'h00);
    snd(PTR_OP_LOCK, USER_LO, 8'h00);
    snd(PTR_OP_END, 8'h00, 8'h00);
    rd(ADDR_EEREG, 8'h01);
    snd(PTR_OP_WRITE, USER_LO, ~data);
    rd(USER_LO, data);
    snd(PTR_OP_WRITE, ADDR_EEREG, 8'h40);
    snd(PTR_OP_END, 8'h00, 8'h00);
    rd(8'h30, 8'hFF);
    snd(PTR_OP_END, 8'h00, 8'h00);
    snd(PTR_OP_LOCK, PARAM_LO, 8'h00);
    rd(ADDR_EEREG, 8'h01);
    snd(PTR_OP_WRITE, ADDR_OV_THR, {1'b0, code});
    rd(ADDR_OV_THR, {1'b0, code});
    meas.cell2 = 10'(678 + 2 * code + 1);
    cyc(30);
    check_bit(ov_fault, 1'b1);
    check_bit(chg_fet_on, 1'b0);
    meas.cell2 = 10'(678 + 2 * code);
    cyc(30);
    check_bit(ov_fault, 1'b0);
    active_rel_capacity = 8'h36; // crosses a 4% step
    cyc(3);
    for (int k = 0; k < 4; k++) begin
      snd(PTR_OP_WRITE, ADDR_GAIN_MSB, {2'(k), 6'h00});
      cyc(3);
      pulse(doc[k] + 1, 40, 1'b0, 1'b1);
      pulse(doc[k], 40, 1'b1, 1'b1);
      pulse(coc[k] - 1, 40, 1'b1, 1'b0);
      pulse(coc[k], 40, 1'b1, 1'b1);
    end
    pulse(101, 20, 1'b1, 1'b1);
    pulse(151, 15, 1'b0, 1'b1);
    snd(PTR_OP_WRITE, ADDR_GAIN_MSB, 8'h20);
    cyc(3);
    pulse(151, 15, 1'b1, 1'b1);
    pulse(301, 15, 1'b0, 1'b1);
    discharge_fet_enable = 1'b0;
    pulse(0, 3, 1'b0, 1'b1);
    cyc(4);
    if (exp_q.size() != 0) fail_count++;
    report_and_stop();
  end
endmodule : test_protector_threshold_and_eeprom_regs
